// file: logic/esc_framer_pkg.sv
package esc_framer_pkg;

    // ************************************************************
    // Framing characters
    // ************************************************************
    localparam logic [7:0] ESC_BYTE  = 8'h1B;
    localparam logic [7:0] CHR_S     = 8'h53;
    localparam logic [7:0] CHR_E     = 8'h45;
    localparam logic [7:0] CHR_Z     = 8'h5A;
    localparam logic [7:0] CHR_U     = 8'h55;
    localparam logic [7:0] CHR_COLON = 8'h3A;
    localparam logic [7:0] CHR_DOT   = 8'h2E;
    localparam logic [7:0] CHR_ZERO  = 8'h30;
    localparam logic [7:0] CHR_NINE  = 8'h39;
    localparam logic [7:0] CHR_LA    = 8'h61;
    localparam logic [7:0] CHR_LF    = 8'h66;
    localparam logic [7:0] CHR_UA    = 8'h41;

    // ************************************************************
    // Widths, counts, word layout and reset values
    // ************************************************************
    localparam int BYTE_W       = 8;
    localparam int CID_W        = 4;
    localparam int LEN_W        = 14;
    localparam int LEN_DIGITS   = 4;
    localparam int BUF_DEPTH    = 8;
    localparam int WORD_LAST    = 12;
    localparam int WORD_CID_LSB = 8;
    localparam int WORD_W       = 13;
    localparam logic [CID_W-1:0] CID_RESET = 4'h0;

    // ************************************************************
    // State and mode types
    // ************************************************************
    typedef enum logic [8:0] {
        D_IDLE = 9'h001, D_TYPE = 9'h002, D_CID  = 9'h004,
        D_LEN  = 9'h008, D_IP   = 9'h010, D_PORT = 9'h020,
        D_DATA = 9'h040, D_ESC  = 9'h080, D_BULK = 9'h100
    } dec_state_t;

    typedef enum logic [6:0] {
        E_IDLE = 7'h01, E_TYPE = 7'h02, E_CID  = 7'h04, E_DATA = 7'h08,
        E_DBL  = 7'h10, E_TESC = 7'h20, E_TE   = 7'h40
    } enc_state_t;

    typedef enum logic [2:0] {
        K_NORMAL = 3'h1, K_BULK = 3'h2, K_UDP = 3'h4
    } frame_kind_t;

endpackage

// file: logic/stream_if.sv
`timescale 1ns/100ps
`default_nettype none
interface stream_if #(parameter int W = 8);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// file: logic/word_fifo.sv
`timescale 1ns/100ps
`default_nettype none
module word_fifo #(
    parameter int W     = 13,
    parameter int DEPTH = 8,
    parameter int CW    = $clog2(DEPTH + 1)
) (
    input  wire logic          clk,
    input  wire logic          rst,
    stream_if.snk              wr,
    stream_if.src              rd,
    output logic [CW-1:0]      count
);
    localparam int AW = $clog2(DEPTH);

    logic [W-1:0]  mem [DEPTH];
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW-1:0] next_wp;
    logic [AW-1:0] next_rp;
    logic [CW-1:0] next_count;
    logic          push;
    logic          pop;

    function automatic logic [AW-1:0] inc(input logic [AW-1:0] p);
        return (p == AW'(DEPTH - 1)) ? '0 : AW'(p + AW'(1));
    endfunction

    always_comb
    begin
        wr.ready   = (count != CW'(DEPTH));
        rd.valid   = (count != '0);
        rd.data    = mem[rp];
        push       = wr.valid && wr.ready;
        pop        = rd.valid && rd.ready;
        next_wp    = push ? inc(wp) : wp;
        next_rp    = pop ? inc(rp) : rp;
        next_count = CW'(count + CW'(push) - CW'(pop));
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            wp    <= '0;
            rp    <= '0;
            count <= '0;
        end
        else
        begin
            wp    <= next_wp;
            rp    <= next_rp;
            count <= next_count;
        end
        if (push)
            mem[wp] <= wr.data;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    chk_fifo_no_overflow: assert property (count == CW'(DEPTH) |=> count <= CW'(DEPTH))
        else $error("fifo count ran past its depth");
endmodule
`default_nettype wire

// file: logic/escaped_socket_data_framer.sv
`timescale 1ns/100ps
`default_nettype none
module escaped_socket_data_framer #(
    parameter int DEPTH = esc_framer_pkg::BUF_DEPTH
) (
    input  wire logic                               clk,
    input  wire logic                               rst,
    input  wire logic                               transparent,
    input  wire logic [esc_framer_pkg::BYTE_W-1:0]  host_data,
    input  wire logic                               host_valid,
    output logic                                    host_ready,
    output logic [esc_framer_pkg::BYTE_W-1:0]       net_data,
    output logic [esc_framer_pkg::CID_W-1:0]        net_cid,
    output logic                                    net_last,
    output logic                                    net_valid,
    input  wire logic                               net_ready,
    output logic [esc_framer_pkg::CID_W-1:0]        cur_cid,
    output logic [31:0]                             udp_ip,
    output logic [15:0]                             udp_port,
    output logic                                    udp_addr_valid,
    output logic                                    frame_error,
    input  wire logic [esc_framer_pkg::BYTE_W-1:0]  tx_data,
    input  wire logic [esc_framer_pkg::CID_W-1:0]   tx_cid,
    input  wire logic                               tx_last,
    input  wire logic                               tx_valid,
    output logic                                    tx_ready,
    output logic [esc_framer_pkg::BYTE_W-1:0]       ser_data,
    output logic                                    ser_valid,
    input  wire logic                               ser_ready
);
    import esc_framer_pkg::*;

    localparam int CW = $clog2(DEPTH + 1);

    // ************************************************************
    // Character helpers
    // ************************************************************
    function automatic logic [4:0] hex_dec(input logic [7:0] b);
        logic [7:0] l;
        l = b | 8'h20;
        if (b >= CHR_ZERO && b <= CHR_NINE)
            return {1'b1, 4'(b - CHR_ZERO)};
        else if (l >= CHR_LA && l <= CHR_LF)
            return {1'b1, 4'(l - CHR_LA + 8'h0A)};
        else
            return 5'h00;
    endfunction

    function automatic logic is_digit(input logic [7:0] b);
        return b >= CHR_ZERO && b <= CHR_NINE;
    endfunction

    function automatic logic [15:0] mul10(input logic [15:0] a, input logic [7:0] b);
        return 16'(a * 16'h000A + 16'(b - CHR_ZERO));
    endfunction

    function automatic logic [7:0] hex_char(input logic [3:0] v);
        return (v < 4'hA) ? 8'(CHR_ZERO + 8'(v)) : 8'(CHR_UA + 8'(v) - 8'h0A);
    endfunction

    // ************************************************************
    // Host to network decoder
    // ************************************************************
    stream_if #(.W(WORD_W)) fin ();
    stream_if #(.W(WORD_W)) fout ();

    dec_state_t       st, next_st;
    frame_kind_t      kind, next_kind;
    logic [CID_W-1:0] cid, next_cid, next_cur;
    logic [7:0]       pend, next_pend;
    logic             pend_v, next_pend_v;
    logic [LEN_W-1:0] len, next_len;
    logic [1:0]       lcnt, next_lcnt;
    logic [7:0]       oct, next_oct;
    logic [31:0]      next_ip;
    logic [15:0]      next_port;
    logic             next_addr_v, next_err;
    logic [CW-1:0]    held, next_held;
    logic [CW-1:0]    cnt;
    logic             acc, push_v;
    logic [WORD_W-1:0] push_w;
    logic [4:0]       hx;

    assign host_ready = fin.ready;
    assign acc        = host_valid && host_ready;
    assign hx         = hex_dec(host_data);
    assign fin.valid  = push_v;
    assign fin.data   = push_w;

    always_comb
    begin
        next_st = st;  next_kind = kind;  next_cid = cid;  next_cur = cur_cid;
        next_pend = pend;  next_pend_v = pend_v;  next_len = len;
        next_lcnt = lcnt;  next_oct = oct;  next_ip = udp_ip;
        next_port = udp_port;  next_addr_v = 1'b0;  next_err = 1'b0;
        push_v = 1'b0;  push_w = '0;
        if (acc)
        begin
            case (st)
                D_IDLE:
                    if (transparent)
                    begin
                        // Single socket, no framing, each byte released at once
                        push_v = 1'b1;
                        push_w = {1'b1, cur_cid, host_data};
                    end
                    else if (host_data == ESC_BYTE)
                        next_st = D_TYPE;
                D_TYPE:
                    if (host_data == CHR_S || host_data == CHR_Z || host_data == CHR_U)
                    begin
                        next_kind = (host_data == CHR_S) ? K_NORMAL :
                                    (host_data == CHR_Z) ? K_BULK : K_UDP;
                        next_st = D_CID;
                    end
                    else
                    begin
                        next_err = 1'b1;
                        next_st  = D_IDLE;
                    end
                D_CID:
                    if (hx[4])
                    begin
                        next_cid = hx[3:0];
                        next_cur = hx[3:0];
                        next_len = '0;
                        next_lcnt = '0;
                        next_oct = '0;
                        next_ip = '0;
                        next_port = '0;
                        next_st = (kind == K_NORMAL) ? D_DATA :
                                  (kind == K_BULK) ? D_LEN : D_IP;
                    end
                    else
                    begin
                        next_err = 1'b1;
                        next_st  = D_IDLE;
                    end
                D_LEN:
                    if (is_digit(host_data))
                    begin
                        next_len  = LEN_W'(mul10(16'(len), host_data));
                        next_lcnt = 2'(lcnt + 2'h1);
                        if (lcnt == 2'(LEN_DIGITS - 1))
                            next_st = (next_len == '0) ? D_IDLE : D_BULK;
                    end
                    else
                    begin
                        next_err = 1'b1;
                        next_st  = D_IDLE;
                    end
                D_IP:
                    if (is_digit(host_data))
                        next_oct = 8'(mul10(16'(oct), host_data));
                    else if (host_data == CHR_DOT || host_data == CHR_COLON)
                    begin
                        next_ip  = {udp_ip[23:0], oct};
                        next_oct = '0;
                        if (host_data == CHR_COLON)
                            next_st = D_PORT;
                    end
                    else
                    begin
                        next_err = 1'b1;
                        next_st  = D_IDLE;
                    end
                D_PORT:
                    if (is_digit(host_data))
                        next_port = mul10(udp_port, host_data);
                    else if (host_data == CHR_COLON)
                    begin
                        next_addr_v = 1'b1;
                        next_st = D_DATA;
                    end
                    else
                    begin
                        next_err = 1'b1;
                        next_st  = D_IDLE;
                    end
                D_DATA:
                    if (host_data == ESC_BYTE)
                        next_st = D_ESC;
                    else
                    begin
                        // One byte kept back so the terminator can mark it last
                        push_v = pend_v;
                        push_w = {1'b0, cid, pend};
                        next_pend = host_data;
                        next_pend_v = 1'b1;
                    end
                D_ESC:
                    if (host_data == ESC_BYTE)
                    begin
                        push_v = pend_v;
                        push_w = {1'b0, cid, pend};
                        next_pend = ESC_BYTE;
                        next_pend_v = 1'b1;
                        next_st = D_DATA;
                    end
                    else
                    begin
                        // Any other byte closes the frame; only E is legal
                        push_v = pend_v;
                        push_w = {1'b1, cid, pend};
                        next_pend_v = 1'b0;
                        next_err = (host_data != CHR_E);
                        next_st = D_IDLE;
                    end
                D_BULK:
                begin
                    push_v = 1'b1;
                    push_w = {len == LEN_W'(1), cid, host_data};
                    next_len = LEN_W'(len - LEN_W'(1));
                    if (len == LEN_W'(1))
                        next_st = D_IDLE;
                end
                default:
                    next_st = D_IDLE;
            endcase
        end
        // Held bytes are released at frame end or when the buffer fills
        next_held = held;
        if (push_v)
            next_held = (push_w[WORD_LAST] || cnt == CW'(DEPTH - 1)) ? '0 :
                        CW'(held + CW'(1));
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            st <= D_IDLE;  kind <= K_NORMAL;  cid <= CID_RESET;
            cur_cid <= CID_RESET;  pend <= '0;  pend_v <= 1'b0;
            len <= '0;  lcnt <= '0;  oct <= '0;  udp_ip <= '0;
            udp_port <= '0;  udp_addr_valid <= 1'b0;  frame_error <= 1'b0;
            held <= '0;
        end
        else
        begin
            st <= next_st;  kind <= next_kind;  cid <= next_cid;
            cur_cid <= next_cur;  pend <= next_pend;  pend_v <= next_pend_v;
            len <= next_len;  lcnt <= next_lcnt;  oct <= next_oct;
            udp_ip <= next_ip;  udp_port <= next_port;
            udp_addr_valid <= next_addr_v;  frame_error <= next_err;
            held <= next_held;
        end
    end

    word_fifo #(.W(WORD_W), .DEPTH(DEPTH), .CW(CW)) u_buf (
        .clk   (clk),
        .rst   (rst),
        .wr    (fin),
        .rd    (fout),
        .count (cnt)
    );

    // Only bytes in front of the held tail may leave
    assign net_valid  = fout.valid && (cnt > held);
    assign fout.ready = net_ready && (cnt > held);
    assign net_data   = fout.data[BYTE_W-1:0];
    assign net_cid    = fout.data[WORD_CID_LSB +: CID_W];
    assign net_last   = fout.data[WORD_LAST];

    // ************************************************************
    // Network to host encoder, normal frames
    // ************************************************************
    enc_state_t       est, next_est;
    logic [CID_W-1:0] tcid, next_tcid;
    logic             tlast, next_tlast;
    logic [7:0]       next_sd;
    logic             next_sv, adv;

    assign adv      = !ser_valid || ser_ready;
    assign tx_ready = adv && (est == E_DATA);

    always_comb
    begin
        next_est = est;  next_tcid = tcid;  next_tlast = tlast;
        next_sd = ser_data;  next_sv = ser_valid && !ser_ready;
        if (adv)
        begin
            case (est)
                E_IDLE:
                    if (tx_valid)
                    begin
                        next_sd = ESC_BYTE;
                        next_sv = 1'b1;
                        next_tcid = tx_cid;
                        next_est = E_TYPE;
                    end
                E_TYPE:
                begin
                    next_sd = CHR_S;  next_sv = 1'b1;  next_est = E_CID;
                end
                E_CID:
                begin
                    next_sd = hex_char(tcid);
                    next_sv = 1'b1;
                    next_est = E_DATA;
                end
                E_DATA:
                    if (tx_valid)
                    begin
                        next_sd = tx_data;  next_sv = 1'b1;  next_tlast = tx_last;
                        next_est = (tx_data == ESC_BYTE) ? E_DBL :
                                   tx_last ? E_TESC : E_DATA;
                    end
                E_DBL:
                begin
                    next_sd = ESC_BYTE;
                    next_sv = 1'b1;
                    next_est = tlast ? E_TESC : E_DATA;
                end
                E_TESC:
                begin
                    next_sd = ESC_BYTE;  next_sv = 1'b1;  next_est = E_TE;
                end
                E_TE:
                begin
                    next_sd = CHR_E;  next_sv = 1'b1;  next_est = E_IDLE;
                end
                default:
                    next_est = E_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            est <= E_IDLE;  tcid <= CID_RESET;  tlast <= 1'b0;
            ser_data <= '0;  ser_valid <= 1'b0;
        end
        else
        begin
            est <= next_est;  tcid <= next_tcid;  tlast <= next_tlast;
            ser_data <= next_sd;  ser_valid <= next_sv;
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    chk_esc_opens: assert property (
        (st == D_IDLE && acc && !transparent && host_data == ESC_BYTE) |=> st == D_TYPE)
        else $error("escape byte did not open a frame header");
    chk_enc_opens: assert property (
        (est == E_IDLE && adv && tx_valid) |=> ser_valid && ser_data == ESC_BYTE ##1
        ser_valid && ser_data == ($past(ser_ready) ? CHR_S : ESC_BYTE))
        else $error("outgoing frame did not open with escape and S");
    chk_cid_digit: assert property (
        (st == D_CID && acc && hx[4]) |=> cid == $past(hx[3:0]) && cur_cid == cid)
        else $error("connection digit not taken");
    chk_route_cid: assert property (
        (push_v && st != D_IDLE) |-> push_w[WORD_CID_LSB +: CID_W] == cid)
        else $error("payload routed to wrong connection");
    chk_hold_frame: assert property (
        (held != '0 && cnt == held) |-> !net_valid)
        else $error("held payload left before frame end");
    chk_full_flush: assert property (
        (push_v && fin.ready && cnt == CW'(DEPTH - 1)) |=> held == '0 && net_valid)
        else $error("full buffer not forwarded");
    chk_bulk_end: assert property (
        (st == D_BULK && acc && len == LEN_W'(1)) |-> push_w[WORD_LAST] ##1 st == D_IDLE)
        else $error("bulk frame did not end on its count");
    chk_udp_addr: assert property (
        $rose(udp_addr_valid) |-> $past(st) == D_PORT && $past(host_data) == CHR_COLON
        ##1 !udp_addr_valid)
        else $error("address strobe without port terminator");
    chk_esc_double: assert property (
        (st == D_ESC && acc && host_data == ESC_BYTE) |=> pend == ESC_BYTE && st == D_DATA)
        else $error("doubled escape not collapsed");
    chk_transparent: assert property (
        (transparent && st == D_IDLE && acc) |-> push_v && push_w[WORD_CID_LSB +: CID_W] == cur_cid)
        else $error("transparent byte not on current connection");

    cov_normal_end: cover property (st == D_ESC && acc && host_data == CHR_E);
    cov_bulk_end: cover property (st == D_BULK && acc && len == LEN_W'(1));
    cov_udp_addr: cover property (udp_addr_valid);
    cov_full_flush: cover property (push_v && cnt == CW'(DEPTH - 1) && !push_w[WORD_LAST]);
endmodule
`default_nettype wire

// file: tb/host_model.sv
`timescale 1ns/100ps
`default_nettype none
module host_model
    import esc_framer_pkg::*;
(
    input  wire logic       clk,
    output logic [7:0]      host_data,
    output logic            host_valid,
    input  wire logic       host_ready,
    input  wire logic [7:0] ser_data,
    input  wire logic       ser_valid,
    output logic            ser_ready
);
    // ****************
    // Host side
    // ****************
    logic [7:0] ser_q[$];
    int         seed = 75108;
    initial
    begin
        host_data = 8'h00;
        host_valid = 1'b0;
        ser_ready = 1'b0;
    end
    function automatic logic [7:0] hexc(input logic [3:0] c);
        return (c < 4'hA) ? CHR_ZERO + 8'(c) : CHR_UA + 8'(c) - 8'h0A;
    endfunction
    task automatic put(input logic [7:0] b);
        @(negedge clk);
        host_data = b;
        host_valid = 1'b1;
        while (!host_ready)
            @(negedge clk);
        @(posedge clk);
    endtask
    // Idle line shows the inverse so a stale byte is never taken for data
    task automatic idle();
        @(negedge clk);
        host_valid = 1'b0;
        host_data = ~host_data;
    endtask
    task automatic frame(input logic [7:0] k, input logic [3:0] c, input logic [7:0] p[$],
                         input logic term);
        string h;
        h = (k == CHR_U) ? "192.168.1.1:52:" : (k == CHR_Z) ? $sformatf("%04d", p.size()) : "";
        put(ESC_BYTE);
        put(k);
        put(hexc(c));
        foreach (h[i])
            put(h[i]);
        foreach (p[i])
        begin
            put(p[i]);
            if (k != CHR_Z && p[i] == ESC_BYTE)
                put(ESC_BYTE);
        end
        if (term && k != CHR_Z)
        begin
            put(ESC_BYTE);
            put(CHR_E);
        end
        idle();
    endtask
    always @(negedge clk)
    begin
        ser_ready = ($random(seed) % 4) != 0;
        #1;
        if (ser_valid && ser_ready)
            ser_q.push_back(ser_data);
    end
endmodule
`default_nettype wire

// file: tb/escaped_socket_data_framer_tb.sv
`timescale 1ns/100ps
`default_nettype none
module escaped_socket_data_framer_tb;
    import esc_framer_pkg::*;
    // ****************
    // Bench
    // ****************
    logic        clk = 1'b0, rst = 1'b1, transparent = 1'b0, net_ready = 1'b0;
    logic [7:0]  host_data, net_data, ser_data, tx_data = 8'h00;
    logic [3:0]  net_cid, cur_cid, c, tx_cid = 4'h0;
    logic [31:0] udp_ip;
    logic [15:0] udp_port;
    logic        host_valid, host_ready, net_last, net_valid, udp_addr_valid, frame_error;
    logic        tx_ready, ser_valid, ser_ready, tx_last = 1'b0, tx_valid = 1'b0;
    logic        addr_seen = 1'b0, err_seen = 1'b0;
    logic [12:0] exp_q[$], exp_w;
    logic [7:0]  p[$], ser_exp[$], kinds[3] = '{CHR_S, CHR_Z, CHR_U};
    int          errors = 0, comparisons = 0, rx_cnt = 0, seed = 75108;
    escaped_socket_data_framer escaped_socket_data_framer_i (.clk(clk), .rst(rst),
        .transparent(transparent), .host_data(host_data), .host_valid(host_valid),
        .host_ready(host_ready), .net_data(net_data), .net_cid(net_cid), .net_last(net_last),
        .net_valid(net_valid), .net_ready(net_ready), .cur_cid(cur_cid), .udp_ip(udp_ip),
        .udp_port(udp_port), .udp_addr_valid(udp_addr_valid), .frame_error(frame_error),
        .tx_data(tx_data), .tx_cid(tx_cid), .tx_last(tx_last), .tx_valid(tx_valid),
        .tx_ready(tx_ready), .ser_data(ser_data), .ser_valid(ser_valid), .ser_ready(ser_ready));
    host_model host_model_i (.clk(clk), .host_data(host_data), .host_valid(host_valid),
        .host_ready(host_ready), .ser_data(ser_data), .ser_valid(ser_valid),
        .ser_ready(ser_ready));
    always #12.5 clk = ~clk;
    always @(posedge clk)
    begin
        addr_seen <= addr_seen | udp_addr_valid;
        err_seen <= err_seen | frame_error;
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic print_verdict();
        if (errors == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // Sink stalls at random so the buffer really fills
    always @(negedge clk)
    begin
        net_ready = ($random(seed) % 4) != 0;
        #1;
        if (net_valid && net_ready)
        begin
            rx_cnt++;
            exp_w = exp_q.size() ? exp_q.pop_front() : 13'h1FFF;
            check({net_last, net_cid, net_data}, exp_w);
        end
    end
    task automatic fill(input int n);
        p.delete();
        repeat (n)
            p.push_back(($random(seed) % 6 == 0) ? ESC_BYTE : 8'($random(seed)));
    endtask
    task automatic drain();
        repeat (400)
            if (exp_q.size() > 0)
                @(negedge clk);
    endtask
    task automatic send(input logic [7:0] k, input logic [3:0] cc, input logic term);
        foreach (p[i])
            exp_q.push_back({i == p.size() - 1, cc, p[i]});
        host_model_i.frame(k, cc, p, term);
        if (term)
            drain();
    endtask
    task automatic close_frame();
        host_model_i.put(ESC_BYTE);
        host_model_i.put(CHR_E);
        host_model_i.idle();
        drain();
    endtask
    task automatic tx_frame();
        ser_exp.push_back(ESC_BYTE);
        ser_exp.push_back(CHR_S);
        ser_exp.push_back(host_model_i.hexc(c));
        foreach (p[i])
        begin
            ser_exp.push_back(p[i]);
            if (p[i] == ESC_BYTE)
                ser_exp.push_back(ESC_BYTE);
            @(negedge clk);
            tx_cid = c;
            tx_data = p[i];
            tx_last = (i == p.size() - 1);
            tx_valid = 1'b1;
            #1;
            // Serial stall changes at the falling edge, so ready is read after it settles
            while (!tx_ready)
            begin
                @(negedge clk);
                #1;
            end
            @(posedge clk);
        end
        ser_exp.push_back(ESC_BYTE);
        ser_exp.push_back(CHR_E);
        @(negedge clk);
        tx_valid = 1'b0;
        tx_data = ~tx_data;
    endtask
    initial
    begin
        repeat (2) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        p = '{8'h48, ESC_BYTE, 8'h6F};
        send(CHR_S, 4'h1, 1'b0);
        repeat (20) @(negedge clk);
        check(rx_cnt, 0);
        close_frame();
        check(rx_cnt, 3);
        check(cur_cid, 4'h1);
        fill(12);
        send(CHR_S, 4'h3, 1'b0);
        repeat (40) @(negedge clk);
        check(rx_cnt >= 11, 1);
        close_frame();
        p = '{ESC_BYTE, 8'h00, ESC_BYTE, CHR_E, 8'h5A};
        send(CHR_Z, 4'h5, 1'b1);
        p = '{8'h48, 8'h69};
        send(CHR_U, 4'h0, 1'b1);
        check(udp_ip, 32'hC0A80101);
        check(udp_port, 16'h0034);
        check(addr_seen, 1'b1);
        host_model_i.put(ESC_BYTE);
        host_model_i.put(8'h51);
        host_model_i.idle();
        repeat (4) @(negedge clk);
        check(err_seen, 1'b1);
        repeat (12)
        begin
            fill(1 + {$random(seed)} % 12);
            c = 4'($random(seed));
            send(kinds[{$random(seed)} % 3], c, 1'b1);
            check(cur_cid, c);
        end
        @(negedge clk);
        transparent = 1'b1;
        exp_q.push_back({1'b1, cur_cid, 8'hA5});
        host_model_i.put(8'hA5);
        host_model_i.idle();
        drain();
        transparent = 1'b0;
        repeat (3)
        begin
            fill(1 + {$random(seed)} % 6);
            c = 4'($random(seed));
            tx_frame();
        end
        repeat (200) @(negedge clk);
        check(host_model_i.ser_q.size(), ser_exp.size());
        foreach (ser_exp[i])
            check(host_model_i.ser_q[i], ser_exp[i]);
        check(exp_q.size(), 0);
        print_verdict();
    end
    initial
    begin
        #750000;
        errors++;
        print_verdict();
    end
endmodule
`default_nettype wire
